/* tb/io_output_instruction_sequencer_test.sv */
`timescale 1ns/1ns
`include "io_seq_regs.vh"
`define CHK(a, b) begin n_checks = n_checks + 1; if ((a) !== (b)) begin \
  err_total = err_total + 1; $display("[ERR] %0t got %h exp %h", $time, a, b); end end
// ==========
// bench top
module io_output_instruction_sequencer_test;
  reg clk = 0;
  reg rstn = 0;
  reg [7:0] avsAddress = 0;
  reg avsRead = 0;
  reg avsWrite = 0;
  reg [31:0] avsWritedata = 0;
  reg irqReq = 0;
  reg slow = 0;
  wire [31:0] avsReaddata, memAddr, ioAddr, savedPc;
  wire [15:0] ioData;
  wire [7:0] memRdata;
  wire avsWaitrequest, memRd, memAck, ioWr, onchipWr, ioWord, ioWait, irqAck;
  integer err_total = 0;
  integer n_checks = 0;
  integer nAll = 0;
  integer nb = 0;
  wire [31:0] nw = nAll - nb; // writes since the last mark
  integer i;
  reg [49:0] wlog [0:511];
  reg [31:0] rd;
  reg [111:0] xs = {16'h003C, 16'h00AA, 16'h0304, 16'h5566, 16'h7788, 16'h99AA, 16'hBEEF};

  // clock
  always #20 clk = ~clk;

  io_output_sequencer uut (.clk(clk), .rstn(rstn), .avsAddress(avsAddress),
    .avsRead(avsRead), .avsWrite(avsWrite), .avsWritedata(avsWritedata),
    .avsReaddata(avsReaddata), .avsWaitrequest(avsWaitrequest), .memRd(memRd),
    .memAddr(memAddr), .memRdata(memRdata), .memAck(memAck), .ioAddr(ioAddr),
    .ioData(ioData), .ioWr(ioWr), .onchipWr(onchipWr), .ioWord(ioWord), .ioWait(ioWait),
    .irqReq(irqReq), .irqAck(irqAck), .savedPc(savedPc));
  io_periph_model far (.clk(clk), .rstn(rstn), .slow(slow), .memRd(memRd),
    .memAddr(memAddr), .memRdata(memRdata), .memAck(memAck), .ioWr(ioWr),
    .onchipWr(onchipWr), .ioWait(ioWait));

  // log each completed i/o write
  always @(posedge clk) if ((ioWr || onchipWr) && !ioWait) begin
    wlog[nw] <= {onchipWr, ioWord, ioAddr, ioData};
    nAll <= nAll + 1;
  end

  function [7:0] mb(input [31:0] a);
    mb = a[7:0] ^ 8'hA5;
  endfunction

  // bus access
  task wr(input [7:0] a, input [31:0] d);
    begin
      @(posedge clk);
      avsAddress <= a;
      avsWritedata <= d;
      avsWrite <= 1'b1;
      do @(posedge clk); while (avsWaitrequest);
      avsWrite <= 1'b0;
    end
  endtask
  task rdr(input [7:0] a);
    begin
      @(posedge clk);
      avsAddress <= a;
      avsRead <= 1'b1;
      do @(posedge clk); while (avsWaitrequest);
      rd = avsReaddata;
      avsRead <= 1'b0;
    end
  endtask
  task rdc(input [7:0] a, input [31:0] m, input [31:0] e);
    begin
      rdr(a);
      `CHK(rd & m, e)
    end
  endtask
  task run(input [31:0] cmd);
    begin
      wr(`OFS_CMD, cmd);
      do rdr(`OFS_STATUS); while (rd[0]);
    end
  endtask
  task end_of_test;
    begin
      $display("checks %0d mismatches %0d", n_checks, err_total);
      if (err_total == 0 && n_checks > 0)
        $display("All checks passed");
      else
        $display("Checks failed");
      $finish;
    end
  endtask

  // watchdog
  initial begin
    #3_000_000;
    err_total = err_total + 1;
    end_of_test;
  end

  // tests
  initial begin
    repeat (2) @(posedge clk);
    rstn <= 1'b1;
    rdc(`OFS_COUNT, 32'hFFFF_FFFF, 32'h0000_0000);
    rdc(`OFS_FLAGS, 32'hFFFF_FFFF, 32'h0000_0000);
    rdc(8'hFC, 32'hFFFF_FFFF, 32'h0000_0000);
    $display("reset test done");
    wr(`OFS_COUNT, 32'h0000_0340);
    wr(`OFS_SRC, 32'h0000_0100);
    wr(`OFS_FLAGS, 32'h0000_00D7);
    nb = nAll;
    run(32'h0000_93ED);
    `CHK(nw, 3)
    for (i = 0; i < 3; i = i + 1)
      `CHK({wlog[i][49:16], wlog[i][7:0]}, {2'b10, 32'h40 + i, mb(32'h100 + i)})
    rdc(`OFS_FLAGS, 32'h0000_00D7, 32'h0000_0046);
    rdc(`OFS_COUNT, 32'hFFFF_FFFF, 32'h0000_0043);
    rdc(`OFS_SRC, 32'hFFFF_FFFF, 32'h0000_0103);
    $display("on-chip test done");
    slow <= 1'b1;
    wr(`OFS_COUNT, 32'h1234_0055);
    wr(`OFS_SRC, 32'h0000_0200);
    wr(`OFS_FLAGS, 32'h0000_0095);
    nb = nAll;
    run(32'h0000_B3ED);
    `CHK(nw, 256)
    for (i = 0; i < 256; i = i + 1)
      `CHK({wlog[i][49:16], wlog[i][7:0]}, {18'h0_1234, 8'hFF - i[7:0], 8'h55, mb(32'h200 + i)})
    rdc(`OFS_FLAGS, 32'h0000_00D7, 32'h0000_00D7);
    rdc(`OFS_COUNT, 32'hFFFF_FFFF, 32'h1234_0055);
    rdc(`OFS_SRC, 32'hFFFF_FFFF, 32'h0000_0300);
    $display("byte repeat test done");
    slow <= 1'b0;
    wr(`OFS_COUNT, 32'hABCD_0002);
    wr(`OFS_WPORT, 32'h0000_8000);
    wr(`OFS_FLAGS, 32'h0000_0000);
    nb = nAll;
    run(32'h0000_F3ED);
    `CHK(nw, 2)
    for (i = 0; i < 2; i = i + 1)
      `CHK(wlog[i], {18'h1_0000, 16'h8000, mb(32'h301 + 2 * i), mb(32'h300 + 2 * i)})
    rdc(`OFS_COUNT, 32'hFFFF_FFFF, 32'hABCD_0000);
    rdc(`OFS_SRC, 32'hFFFF_FFFF, 32'h0000_0304);
    rdc(`OFS_FLAGS, 32'h0000_00D7, 32'h0000_0042);
    $display("word repeat test done");
    wr(`OFS_FLAGS, 32'h0000_0081);
    wr(`OFS_COUNT, 32'h0102_0304);
    wr(`OFS_WPORT, 32'h0000_5566);
    wr(`OFS_SRC, 32'h0000_7788);
    wr(`OFS_OPND, 32'h0000_99AA);
    nb = nAll;
    run(32'h003C_71ED);
    run(32'h0000_41ED);
    run(32'h0000_41DD);
    run(32'h0000_51DD);
    run(32'h0000_79DD);
    run(32'h0000_49DD);
    run(32'hBEEF_79FD);
    wr(`OFS_CMD, 32'h0000_00ED);
    rdc(`OFS_STATUS, 32'h0000_0007, 32'h0000_0004);
    `CHK(nw, 7)
    for (i = 0; i < 7; i = i + 1)
      `CHK({wlog[i][49:16], wlog[i][15:0] & (i > 1 ? 16'hFFFF : 16'h00FF)},
        {1'b0, i > 1, 32'h0102_0304, xs[16 * (6 - i) +: 16]})
    rdc(`OFS_FLAGS, 32'h0000_00FF, 32'h0000_0081);
    $display("single output test done");
    slow <= 1'b1;
    wr(`OFS_COUNT, 32'h0000_0810);
    wr(`OFS_SRC, 32'h0000_0400);
    wr(`OFS_STARTPC, 32'h0000_1234);
    nb = nAll;
    wr(`OFS_CMD, 32'h0000_B3ED);
    while (nw < 2) @(posedge clk);
    irqReq <= 1'b1;
    do @(posedge clk); while (!irqAck);
    `CHK(savedPc, 32'h0000_1234)
    irqReq <= 1'b0;
    rdc(`OFS_STATUS, 32'h0000_0003, 32'h0000_0002);
    rdr(`OFS_COUNT);
    `CHK(rd[15:8], 8'h08 - nw[7:0])
    run(32'h0000_B3ED);
    `CHK(nw, 8)
    `CHK(wlog[7][47:16], 32'h0000_0010)
    for (i = 0; i < 8; i = i + 1)
      `CHK(wlog[i][7:0], mb(32'h400 + i))
    $display("interrupt test done");
    end_of_test;
  end
endmodule // io_output_instruction_sequencer_test

/* tb/io_periph_model.sv */
`timescale 1ns/1ns
// ==========
// memory and peripheral answers
module io_periph_model (
  // clock and reset
  input wire clk,
  input wire rstn,
  input wire slow,
  // memory side
  input wire memRd,
  input wire [31:0] memAddr,
  output reg [7:0] memRdata,
  output reg memAck,
  // i/o side
  input wire ioWr,
  input wire onchipWr,
  output reg ioWait
);
  reg [1:0] lat;
  // memory answers fast or after three waits; data moves when idle
  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      memAck <= 1'b0;
      memRdata <= 8'h00;
      lat <= 2'h0;
      ioWait <= 1'b0;
    end else begin
      memAck <= 1'b0;
      memRdata <= ~memRdata;
      ioWait <= slow & ~(ioWait & (ioWr | onchipWr)); // one stall per write
      if (memRd && !memAck) begin
        lat <= lat + 2'h1;
        if (!slow || lat == 2'h3) begin
          memAck <= 1'b1;
          memRdata <= memAddr[7:0] ^ 8'hA5;
          lat <= 2'h0;
        end
      end
    end
  end
endmodule // io_periph_model

/* tb/io_seq_monitor.sv */
`timescale 1ns/1ns
// ==========
// port checks
module io_seq_monitor (
  // clock and reset
  input wire clk,
  input wire rstn,
  // memory port
  input wire memRd,
  input wire [31:0] memAddr,
  input wire memAck,
  // i/o port
  input wire [31:0] ioAddr,
  input wire [15:0] ioData,
  input wire ioWr,
  input wire onchipWr,
  input wire ioWord,
  input wire ioWait,
  // interrupt
  input wire irqReq,
  input wire irqAck
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rstn);
  // strobe, fetch and interrupt timing
  onchip_no_ext_a: assert property (onchipWr |-> !ioWr && !ioWord && ioAddr[31:8] == 0)
    else $error("on-chip write shows on bus");
  io_hold_a: assert property ((ioWr || onchipWr) && ioWait |=>
    (ioWr || onchipWr) && $stable(ioAddr) && $stable(ioData)) else $error("i/o cycle moved");
  io_gap_a: assert property ((ioWr || onchipWr) && !ioWait |=> !ioWr && !onchipWr)
    else $error("strobe kept after completion");
  mem_hold_a: assert property (memRd && !memAck |=> memRd && $stable(memAddr))
    else $error("fetch moved before answer");
  mem_drop_a: assert property (memRd && memAck |=> !memRd)
    else $error("fetch kept after answer");
  ack_pulse_a: assert property (irqAck |=> !irqAck)
    else $error("interrupt ack too long");
  ack_between_a: assert property (irqAck |-> !ioWr && !onchipWr && !memRd)
    else $error("interrupt taken mid iteration");
  irq_no_fetch_a: assert property (irqReq && !memRd |=> !memRd)
    else $error("fetch while interrupt pending");
endmodule // io_seq_monitor

bind io_output_sequencer io_seq_monitor mon (.clk(clk), .rstn(rstn), .memRd(memRd),
  .memAddr(memAddr), .memAck(memAck), .ioAddr(ioAddr), .ioData(ioData), .ioWr(ioWr),
  .onchipWr(onchipWr), .ioWord(ioWord), .ioWait(ioWait), .irqReq(irqReq), .irqAck(irqAck));

/* verilog/io_output_sequencer.v */
// Behaviour
// - on-chip repeat: write byte to port index, bump index and pointer, count down
// - on-chip repeat: no external cycle; port on low address byte, rest zero
// - byte repeat with zero start count transfers 256 bytes
// - on-chip repeat end: S H C cleared, Z P set, N is byte msb
// - repeats take interrupts between iterations, saving the start program counter
// - byte repeat: count down first, address is whole count pair, pointer plus one
// - byte and word repeat: Z from decrement, N set, other flags kept
// - word repeat: low 16 count bits down, word port address, pointer plus two
// - single byte output of register or immediate to count pair address, flags kept
// - single word output from pair or immediate word in one word write, flags kept
// - pair field: 000 count pair, 010 word port address, 111 source pointer
// - byte repeat drives address bits 15 to 8 from the decremented count
//
// Added by the designer: register access over Avalon-MM and the register offsets.
`timescale 1ns/1ns
`include "io_seq_regs.vh"
module io_output_sequencer #(
  parameter FIFO_DEPTH = `FIFO_DEPTH,
  parameter FIFO_AW = 4
) (
  // clock and reset
  input wire clk,
  input wire rstn,
  // avalon-mm slave
  input wire [7:0] avsAddress,
  input wire avsRead,
  input wire avsWrite,
  input wire [31:0] avsWritedata,
  output wire [31:0] avsReaddata,
  output wire avsWaitrequest,
  // source memory read port
  output wire memRd,
  output wire [31:0] memAddr,
  input wire [7:0] memRdata,
  input wire memAck,
  // i/o bus
  output wire [31:0] ioAddr,
  output wire [15:0] ioData,
  output wire ioWr,
  output wire onchipWr,
  output wire ioWord,
  input wire ioWait,
  // interrupt handshake
  input wire irqReq,
  output wire irqAck,
  output wire [31:0] savedPc
);
  // ==========================================
  // states and instruction kinds
  localparam S_IDLE = 2'b01;
  localparam S_RUN = 2'b10;
  localparam K_BAD = 3'd0;
  localparam K_ONCHIP = 3'd1;
  localparam K_BYTEREP = 3'd2;
  localparam K_WORDREP = 3'd3;
  localparam K_OUTB = 3'd4;
  localparam K_SINGLE_WORD_OUTPUT = 3'd5;

  reg [1:0] state_q;
  reg [2:0] kind_q;
  reg [31:0] count_q;
  reg [31:0] wport_q;
  reg [31:0] src_q;
  reg [7:0] flags_q;
  reg [31:0] opnd_q;
  reg [31:0] startPc_q;
  reg [31:0] savedPc_q;
  reg irqTaken_q;
  reg badOp_q;
  reg [31:0] rdData_q;
  reg rdAck_q;
  reg [31:0] fAddr_q;
  reg [16:0] fRem_q;
  reg half_q;
  reg [7:0] lo_q;
  reg memRd_q;
  reg pushV_q;
  reg [15:0] pushD_q;
  reg ioActive_q;
  reg [31:0] ioAddr_q;
  reg [15:0] ioData_q;
  reg ioWr_q;
  reg onchipWr_q;
  reg ioWord_q;
  reg msb_q;
  reg irqAck_q;

  // ==========================================
  // decoding helpers
  function [2:0] decodeKind;
    input [7:0] b1;
    input [7:0] b2;
    begin
      decodeKind = K_BAD;
      if (b1 == `OPC_PFX_ED) begin
        if (b2 == `OPC_ONCHIP_REP) begin
          decodeKind = K_ONCHIP;
        end else if (b2 == `OPC_BYTE_REP) begin
          decodeKind = K_BYTEREP;
        end else if (b2 == `OPC_WORD_REP) begin
          decodeKind = K_WORDREP;
        end else if (b2[7:6] == 2'b01 && b2[2:0] == 3'b001) begin
          decodeKind = K_OUTB;
        end
      end else if (b1 == `OPC_PFX_DD && b2[7:6] == 2'b01 && b2[2:0] == 3'b001) begin
        decodeKind = K_SINGLE_WORD_OUTPUT;
      end else if (b1 == `OPC_PFX_FD && b2 == `OPC_SINGLE_WORD_OUTPUT_IMM) begin
        decodeKind = K_SINGLE_WORD_OUTPUT;
      end
    end
  endfunction

  // pair selection for word output
  function [15:0] pairValue;
    input [2:0] rrr;
    input [31:0] cnt;
    input [31:0] wp;
    input [31:0] sp;
    input [31:0] other;
    begin
      case (rrr)
        `RP_COUNT: pairValue = cnt[15:0];
        `RP_WPORT: pairValue = wp[15:0];
        `RP_SRC: pairValue = sp[15:0];
        default: pairValue = other[15:0];
      endcase
    end
  endfunction

  // ==========================================
  // bus decode
  wire busy = state_q[1];
  wire isRep = (kind_q == K_ONCHIP) | (kind_q == K_BYTEREP) | (kind_q == K_WORDREP);
  wire wrOk = avsWrite & ~busy;
  wire [7:0] cb1 = avsWritedata[`CMD_B1_LSB +: 8];
  wire [7:0] cb2 = avsWritedata[`CMD_B2_LSB +: 8];
  wire [15:0] cimm = avsWritedata[`CMD_IMM_LSB +: 16];
  wire [2:0] newKind = decodeKind(cb1, cb2);
  wire startCmd = wrOk & (avsAddress == `OFS_CMD);
  assign avsWaitrequest = (avsRead & ~rdAck_q) | (avsWrite & busy);
  assign avsReaddata = rdData_q;

  // ==========================================
  // loop arithmetic
  wire [7:0] bDec = count_q[15:8] - 8'h01;
  wire [15:0] wordCntDec = count_q[15:0] - 16'h0001;
  wire [16:0] loopLen = (newKind == K_WORDREP) ?
    ((count_q[15:0] == 16'h0000) ? `FULL_WORD_LOOP : {1'b0, count_q[15:0]}) :
    ((count_q[15:8] == 8'h00) ? `FULL_BYTE_LOOP : {9'h000, count_q[15:8]});

  // ==========================================
  // fifo between memory fetch and i/o write
  wire fifoInReady;
  wire fifoOutValid;
  wire [15:0] fifoOutData;
  wire run = busy & isRep;
  wire takeIrq = run & irqReq & ~ioActive_q & ~memRd_q;
  wire ioDone = ioActive_q & ~ioWait;
  wire lastIter = ioDone & (kind_q == K_WORDREP ? (wordCntDec == 16'h0000) : (bDec == 8'h00));
  wire endRun = ioDone & (~isRep | lastIter);
  wire popReady = run & ~ioActive_q & ~takeIrq;
  wire flushFifo = takeIrq | endRun | startCmd;

  seq_fifo #(
    .W(16),
    .DEPTH(FIFO_DEPTH),
    .AW(FIFO_AW)
  ) dataFifo (
    .clk(clk),
    .rstn(rstn),
    .flush(flushFifo),
    .inValid(pushV_q),
    .inReady(fifoInReady),
    .inData(pushD_q),
    .outValid(fifoOutValid),
    .outReady(popReady),
    .outData(fifoOutData)
  );

  // ==========================================
  // register read path
  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      rdData_q <= `RST_WORD;
      rdAck_q <= 1'b0;
    end else begin
      rdAck_q <= avsRead & ~rdAck_q;
      if (avsRead & ~rdAck_q) begin
        case (avsAddress)
          `OFS_COUNT: rdData_q <= count_q;
          `OFS_WPORT: rdData_q <= wport_q;
          `OFS_SRC: rdData_q <= src_q;
          `OFS_FLAGS: rdData_q <= {24'h00_0000, flags_q};
          `OFS_STATUS: rdData_q <= {29'h0000_0000, badOp_q, irqTaken_q, busy};
          `OFS_SAVEDPC: rdData_q <= savedPc_q;
          `OFS_STARTPC: rdData_q <= startPc_q;
          `OFS_OPND: rdData_q <= opnd_q;
          default: rdData_q <= `RST_WORD;
        endcase
      end
    end
  end

  // ==========================================
  // source fetch: bytes ascending, words paired low first
  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      fAddr_q <= `RST_WORD;
      fRem_q <= 17'h0_0000;
      half_q <= 1'b0;
      lo_q <= 8'h00;
      memRd_q <= 1'b0;
      pushV_q <= 1'b0;
      pushD_q <= 16'h0000;
    end else if (startCmd) begin
      fAddr_q <= src_q;
      fRem_q <= loopLen;
      half_q <= 1'b0;
      memRd_q <= 1'b0;
      pushV_q <= 1'b0;
    end else if (takeIrq | endRun) begin
      fRem_q <= 17'h0_0000;
      half_q <= 1'b0;
      pushV_q <= 1'b0;
    end else begin
      if (pushV_q & fifoInReady) begin
        pushV_q <= 1'b0;
      end
      if (memRd_q & memAck) begin
        memRd_q <= 1'b0;
        fAddr_q <= fAddr_q + 32'h0000_0001;
        if (kind_q == K_WORDREP && !half_q) begin
          lo_q <= memRdata;
          half_q <= 1'b1;
        end else begin
          pushD_q <= (kind_q == K_WORDREP) ? {memRdata, lo_q} : {8'h00, memRdata};
          pushV_q <= 1'b1;
          half_q <= 1'b0;
          fRem_q <= fRem_q - 17'h0_0001;
        end
      end else if (run & ~memRd_q & ~pushV_q & (fRem_q != 17'h0_0000) & ~irqReq) begin
        memRd_q <= 1'b1;
      end
    end
  end
  assign memRd = memRd_q;
  assign memAddr = fAddr_q;

  // ==========================================
  // sequencer: start, i/o cycles, register and flag updates
  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      state_q <= S_IDLE;
      kind_q <= K_BAD;
      count_q <= `RST_WORD;
      wport_q <= `RST_WORD;
      src_q <= `RST_WORD;
      flags_q <= `RST_FLAGS;
      opnd_q <= `RST_WORD;
      startPc_q <= `RST_WORD;
      savedPc_q <= `RST_WORD;
      irqTaken_q <= 1'b0;
      badOp_q <= 1'b0;
      ioActive_q <= 1'b0;
      ioAddr_q <= `RST_WORD;
      ioData_q <= 16'h0000;
      ioWr_q <= 1'b0;
      onchipWr_q <= 1'b0;
      ioWord_q <= 1'b0;
      msb_q <= 1'b0;
      irqAck_q <= 1'b0;
    end else begin
      irqAck_q <= 1'b0;
      case (state_q)
        S_IDLE: begin
          if (wrOk) begin
            case (avsAddress)
              `OFS_COUNT: count_q <= avsWritedata;
              `OFS_WPORT: wport_q <= avsWritedata;
              `OFS_SRC: src_q <= avsWritedata;
              `OFS_FLAGS: flags_q <= avsWritedata[7:0];
              `OFS_STARTPC: startPc_q <= avsWritedata;
              `OFS_OPND: opnd_q <= avsWritedata;
              default: flags_q <= flags_q;
            endcase
          end
          if (startCmd) begin
            kind_q <= newKind;
            irqTaken_q <= 1'b0;
            badOp_q <= (newKind == K_BAD);
            if (newKind != K_BAD) begin
              state_q <= S_RUN;
            end
            if (newKind == K_OUTB) begin
              ioAddr_q <= count_q;
              ioData_q <= {8'h00, (cb2 == `OPC_OUTB_IMM) ? cimm[7:0] : opnd_q[7:0]};
              ioWr_q <= 1'b1;
              ioWord_q <= 1'b0;
              ioActive_q <= 1'b1;
            end else if (newKind == K_SINGLE_WORD_OUTPUT) begin
              ioAddr_q <= count_q;
              ioData_q <= (cb1 == `OPC_PFX_FD) ? cimm :
                pairValue(cb2[5:3], count_q, wport_q, src_q, opnd_q);
              ioWr_q <= 1'b1;
              ioWord_q <= 1'b1;
              ioActive_q <= 1'b1;
            end
          end
        end
        S_RUN: begin
          if (takeIrq) begin
            savedPc_q <= startPc_q;
            irqTaken_q <= 1'b1;
            irqAck_q <= 1'b1;
            state_q <= S_IDLE;
          end else if (fifoOutValid & popReady) begin
            ioActive_q <= 1'b1;
            ioData_q <= fifoOutData;
            msb_q <= fifoOutData[7];
            if (kind_q == K_ONCHIP) begin
              ioAddr_q <= {24'h00_0000, count_q[7:0]};
              onchipWr_q <= 1'b1;
            end else if (kind_q == K_BYTEREP) begin
              ioAddr_q <= {count_q[31:16], bDec, count_q[7:0]};
              ioWr_q <= 1'b1;
            end else begin
              ioAddr_q <= wport_q;
              ioWr_q <= 1'b1;
              ioWord_q <= 1'b1;
            end
          end else if (ioDone) begin
            ioActive_q <= 1'b0;
            ioWr_q <= 1'b0;
            onchipWr_q <= 1'b0;
            ioWord_q <= 1'b0;
            if (endRun) begin
              state_q <= S_IDLE;
            end
            if (kind_q == K_ONCHIP) begin
              count_q[7:0] <= count_q[7:0] + 8'h01;
              count_q[15:8] <= bDec;
              src_q <= src_q + 32'h0000_0001;
              if (lastIter) begin
                flags_q[`FLG_S] <= 1'b0;
                flags_q[`FLG_Z] <= 1'b1;
                flags_q[`FLG_H] <= 1'b0;
                flags_q[`FLG_PV] <= 1'b1;
                flags_q[`FLG_C] <= 1'b0;
                flags_q[`FLG_N] <= msb_q;
              end
            end else if (kind_q == K_BYTEREP) begin
              count_q[15:8] <= bDec;
              src_q <= src_q + 32'h0000_0001;
              flags_q[`FLG_Z] <= (bDec == 8'h00);
              flags_q[`FLG_N] <= 1'b1;
            end else if (kind_q == K_WORDREP) begin
              count_q[15:0] <= wordCntDec;
              src_q <= src_q + 32'h0000_0002;
              flags_q[`FLG_Z] <= (wordCntDec == 16'h0000);
              flags_q[`FLG_N] <= 1'b1;
            end
          end
        end
        default: state_q <= S_IDLE;
      endcase
    end
  end

  // ==========================================
  // output drivers
  assign ioAddr = ioAddr_q;
  assign ioData = ioData_q;
  assign ioWr = ioWr_q;
  assign onchipWr = onchipWr_q;
  assign ioWord = ioWord_q;
  assign irqAck = irqAck_q;
  assign savedPc = savedPc_q;
endmodule // io_output_sequencer

/* verilog/io_seq_regs.vh */
`ifndef IO_SEQ_REGS_VH
`define IO_SEQ_REGS_VH
// ==========================================
// register byte offsets
`define OFS_CMD 8'h00
`define OFS_COUNT 8'h04
`define OFS_WPORT 8'h08
`define OFS_SRC 8'h0C
`define OFS_FLAGS 8'h10
`define OFS_STATUS 8'h14
`define OFS_SAVEDPC 8'h18
`define OFS_STARTPC 8'h1C
`define OFS_OPND 8'h20
// ==========================================
// reset values
`define RST_WORD 32'h0000_0000
`define RST_FLAGS 8'h00
// ==========================================
// command field positions
`define CMD_B1_LSB 0
`define CMD_B2_LSB 8
`define CMD_IMM_LSB 16
// ==========================================
// flag bit positions
`define FLG_S 7
`define FLG_Z 6
`define FLG_H 4
`define FLG_PV 2
`define FLG_N 1
`define FLG_C 0
// ==========================================
// status bit positions
`define ST_BUSY 0
`define ST_IRQ 1
`define ST_BADOP 2
// ==========================================
// opcode bytes
`define OPC_PFX_ED 8'hED
`define OPC_PFX_DD 8'hDD
`define OPC_PFX_FD 8'hFD
`define OPC_ONCHIP_REP 8'h93
`define OPC_BYTE_REP 8'hB3
`define OPC_WORD_REP 8'hF3
`define OPC_OUTB_IMM 8'h71
`define OPC_SINGLE_WORD_OUTPUT_IMM 8'h79
// ==========================================
// register-pair field codes
`define RP_COUNT 3'h0
`define RP_WPORT 3'h2
`define RP_SRC 3'h7
// ==========================================
// loop sizes and buffer depth
`define FULL_BYTE_LOOP 17'h0_0100
`define FULL_WORD_LOOP 17'h1_0000
`define FIFO_DEPTH 16
`endif

/* verilog/seq_fifo.v */
`timescale 1ns/1ns
// ==========================================
// synchronous fifo with flush
module seq_fifo #(
  parameter W = 16,
  parameter DEPTH = 16,
  parameter AW = 4
) (
  // clock and reset
  input wire clk,
  input wire rstn,
  input wire flush,
  // fill side
  input wire inValid,
  output wire inReady,
  input wire [W-1:0] inData,
  // drain side
  output wire outValid,
  input wire outReady,
  output wire [W-1:0] outData
);
  reg [W-1:0] mem [0:DEPTH-1];
  reg [AW-1:0] wrPtr_q;
  reg [AW-1:0] rdPtr_q;
  reg [AW:0] count_q;
  wire push;
  wire pop;

  // handshake terms
  assign inReady = (count_q != DEPTH[AW:0]);
  assign outValid = (count_q != {(AW+1){1'b0}});
  assign outData = mem[rdPtr_q];
  assign push = inValid & inReady;
  assign pop = outValid & outReady;

  // storage array
  always @(posedge clk) begin
    if (push) begin
      mem[wrPtr_q] <= inData;
    end
  end

  // pointers and fill count
  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      wrPtr_q <= {AW{1'b0}};
      rdPtr_q <= {AW{1'b0}};
      count_q <= {(AW+1){1'b0}};
    end else if (flush) begin
      wrPtr_q <= {AW{1'b0}};
      rdPtr_q <= {AW{1'b0}};
      count_q <= {(AW+1){1'b0}};
    end else begin
      if (push) begin
        wrPtr_q <= (wrPtr_q == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : wrPtr_q + 1'b1;
      end
      if (pop) begin
        rdPtr_q <= (rdPtr_q == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : rdPtr_q + 1'b1;
      end
      if (push & ~pop) begin
        count_q <= count_q + 1'b1;
      end else if (pop & ~push) begin
        count_q <= count_q - 1'b1;
      end
    end
  end
endmodule // seq_fifo
